// file: hw/picture_regs_pkg.sv
package picture_regs_pkg;

    // Register indices (printed offsets are not all multiples of four: byte offset is index times four)
    localparam logic [7:0] IDX_LUMA_A = 8'h07;
    localparam logic [7:0] IDX_LUMA_B = 8'h08;
    localparam logic [7:0] IDX_BRIGHT = 8'h09;
    localparam logic [7:0] IDX_SAT = 8'h0a;
    localparam logic [7:0] IDX_HUE = 8'h0b;
    localparam logic [7:0] IDX_CONTRAST = 8'h0c;
    localparam logic [7:0] IDX_CODING = 8'h0d;
    localparam logic [7:0] IDX_NOTCH = 8'h0e;
    localparam logic [7:0] IDX_PINS = 8'h0f;
    localparam logic [7:0] IDX_CROP_HI = 8'h11;
    localparam logic [7:0] IDX_CROP_LO = 8'h12;
    localparam logic [7:0] IDX_MISC = 8'h13;

    // Reset values
    localparam logic [7:0] RST_LUMA_A = 8'h60;
    localparam logic [7:0] RST_LUMA_B = 8'h00;
    localparam logic [7:0] RST_BRIGHT = 8'h80;
    localparam logic [7:0] RST_SAT = 8'h80;
    localparam logic [7:0] RST_HUE = 8'h00;
    localparam logic [7:0] RST_CONTRAST = 8'h80;
    localparam logic [7:0] RST_CODING = 8'h47;
    localparam logic [7:0] RST_NOTCH = 8'h00;
    localparam logic [7:0] RST_PINS = 8'h08;
    localparam logic [7:0] RST_CROP_HI = 8'h00;
    localparam logic [7:0] RST_CROP_LO = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h00;

    // Writable bit masks; other bits are reserved
    localparam logic [7:0] MASK_LUMA_B = 8'h4f;
    localparam logic [7:0] MASK_CODING = 8'h7f;
    localparam logic [7:0] MASK_NOTCH = 8'h03;
    localparam logic [7:0] MASK_PINS = 8'h5f;
    localparam logic [7:0] MASK_CROP_LO = 8'h03;
    localparam logic [7:0] MASK_MISC = 8'h80;

    // Field positions
    localparam int LA_DOUBLE = 7;
    localparam int LA_NO_PEDESTAL = 6;
    localparam int LA_RAW_HDR_OFF = 5;
    localparam int LA_VBLANK_BYPASS = 4;
    localparam int LB_TRAP = 6;
    localparam int PIN_A_LOCK = 6;
    localparam int PIN_B_LOCK = 4;
    localparam int PIN_FID_SEL = 3;
    localparam int PIN_VS_SEL = 2;
    localparam int PIN_GP_SEL = 1;
    localparam int PIN_CLK_SEL = 0;
    localparam int CD_RANGE = 6;
    localparam int CD_FORMAT = 5;
    localparam int MISC_GP_VERTICAL_BLANK_OUT = 7;

    localparam logic [7:0] DUMMY_HDR = 8'h40;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        LUMA_YCBCR,
        LUMA_DOUBLE
    } luma_mode_t;

    typedef enum logic [1:0] {
        PEAK_0,
        PEAK_HALF,
        PEAK_1,
        PEAK_2
    } peak_gain_t;

    typedef enum logic [1:0] {
        AGC_AUTO,
        AGC_FORCE_OFF,
        AGC_FORCE_ON
    } agc_mode_t;

    // Shared pin state inputs
    typedef struct packed {
        logic field_id;
        logic genlock;
        logic vsync;
        logic pal_line;
        logic hv_lock;
        logic irq;
        logic gp_line;
        logic vblank;
        logic sys_clk;
        logic pix_clk;
    } pin_sources_t;

    typedef struct packed {
        logic field_identity_out;
        logic vsync_pal_out;
        logic interrupt_request_out;
        logic clock_out;
    } pin_outputs_t;

    // Settings handed to the pixel pipeline
    typedef struct packed {
        luma_mode_t luma_mode;
        logic pedestal_present;
        logic raw_header_real;
        logic [7:0] header_byte;
        logic signed [3:0] luma_delay;
        logic trap_filter;
        peak_gain_t peak_gain;
        agc_mode_t agc_mode;
        logic [7:0] brightness;
        logic [7:0] saturation;
        logic signed [7:0] hue;
        logic [7:0] contrast;
        logic [7:0] y_min;
        logic [7:0] y_max;
        logic [7:0] c_min;
        logic [7:0] c_max;
        logic chroma_twos;
        logic [1:0] bypass_sel;
        logic [2:0] out_format;
        logic [1:0] notch_sel;
        logic signed [9:0] crop_start;
    } picture_cfg_t;

endpackage : picture_regs_pkg

// file: hw/picture_regs.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
module picture_regs (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic secam_in,
    input wire logic vblank_window_in,
    input wire logic wide_notch_bit_in,
    input wire picture_regs_pkg::pin_sources_t pins_in,
    output picture_regs_pkg::picture_cfg_t cfg_out,
    output picture_regs_pkg::pin_outputs_t pins_out
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] luma_a_reg, luma_b_reg, bright_reg, sat_reg, hue_reg, contrast_reg;
    logic [7:0] coding_reg, notch_reg, pins_reg, crop_hi_reg, crop_lo_reg, misc_reg;
    logic signed [9:0] crop_start_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_full_reg, w_full_reg;
    logic [2:0] vblank_sync_reg;
    logic vblank_reg;
    logic [7:0] wsel_idx, rsel_idx;
    logic wr_fire, wr_hit, rd_hit;
    logic [7:0] wbyte, rbyte;

    assign wsel_idx = {2'b00, aw_addr_reg[7:2]};
    assign rsel_idx = {2'b00, s_axi_araddr_in[7:2]};
    assign wbyte = w_data_reg[7:0];
    assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid_out && w_strb_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Address and data may arrive in either order; each is held until both are in
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= picture_regs_pkg::RESP_OKAY;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
        end else if (clk_en_in) begin
            s_axi_awready_out <= !aw_full_reg && !(s_axi_awvalid_in && s_axi_awready_out);
            s_axi_wready_out <= !w_full_reg && !(s_axi_wvalid_in && s_axi_wready_out);
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (aw_full_reg && w_full_reg && !s_axi_bvalid_out) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_hit ? picture_regs_pkg::RESP_OKAY : picture_regs_pkg::RESP_SLVERR;
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    always_comb begin
        case (wsel_idx)
            picture_regs_pkg::IDX_LUMA_A, picture_regs_pkg::IDX_LUMA_B, picture_regs_pkg::IDX_BRIGHT,
            picture_regs_pkg::IDX_SAT, picture_regs_pkg::IDX_HUE, picture_regs_pkg::IDX_CONTRAST,
            picture_regs_pkg::IDX_CODING, picture_regs_pkg::IDX_NOTCH, picture_regs_pkg::IDX_PINS,
            picture_regs_pkg::IDX_CROP_HI, picture_regs_pkg::IDX_CROP_LO, picture_regs_pkg::IDX_MISC:
                wr_hit = (aw_addr_reg[1:0] == 2'b00);
            default: wr_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file; only byte lane 0 carries data
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            luma_a_reg <= picture_regs_pkg::RST_LUMA_A;
            luma_b_reg <= picture_regs_pkg::RST_LUMA_B;
            bright_reg <= picture_regs_pkg::RST_BRIGHT;
            sat_reg <= picture_regs_pkg::RST_SAT;
            hue_reg <= picture_regs_pkg::RST_HUE;
            contrast_reg <= picture_regs_pkg::RST_CONTRAST;
            coding_reg <= picture_regs_pkg::RST_CODING;
            notch_reg <= picture_regs_pkg::RST_NOTCH;
            pins_reg <= picture_regs_pkg::RST_PINS;
            crop_hi_reg <= picture_regs_pkg::RST_CROP_HI;
            crop_lo_reg <= picture_regs_pkg::RST_CROP_LO;
            misc_reg <= picture_regs_pkg::RST_MISC;
        end else if (clk_en_in && wr_fire && wr_hit) begin
            case (wsel_idx)
                picture_regs_pkg::IDX_LUMA_A: luma_a_reg <= wbyte;
                picture_regs_pkg::IDX_LUMA_B: luma_b_reg <= wbyte & picture_regs_pkg::MASK_LUMA_B;
                picture_regs_pkg::IDX_BRIGHT: bright_reg <= wbyte;
                picture_regs_pkg::IDX_SAT: sat_reg <= wbyte;
                picture_regs_pkg::IDX_HUE: hue_reg <= wbyte;
                picture_regs_pkg::IDX_CONTRAST: contrast_reg <= wbyte;
                picture_regs_pkg::IDX_CODING: coding_reg <= wbyte & picture_regs_pkg::MASK_CODING;
                picture_regs_pkg::IDX_NOTCH: notch_reg <= wbyte & picture_regs_pkg::MASK_NOTCH;
                picture_regs_pkg::IDX_PINS: pins_reg <= wbyte & picture_regs_pkg::MASK_PINS;
                picture_regs_pkg::IDX_CROP_HI: crop_hi_reg <= wbyte;
                picture_regs_pkg::IDX_CROP_LO: crop_lo_reg <= wbyte & picture_regs_pkg::MASK_CROP_LO;
                picture_regs_pkg::IDX_MISC: misc_reg <= wbyte & picture_regs_pkg::MASK_MISC;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            crop_start_reg <= 10'sh000;
        end else if (clk_en_in && wr_fire && wr_hit && wsel_idx == picture_regs_pkg::IDX_CROP_LO) begin
            crop_start_reg <= {crop_hi_reg, wbyte[1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        rd_hit = (s_axi_araddr_in[1:0] == 2'b00);
        case (rsel_idx)
            picture_regs_pkg::IDX_LUMA_A: rbyte = luma_a_reg;
            picture_regs_pkg::IDX_LUMA_B: rbyte = luma_b_reg;
            picture_regs_pkg::IDX_BRIGHT: rbyte = bright_reg;
            picture_regs_pkg::IDX_SAT: rbyte = sat_reg;
            picture_regs_pkg::IDX_HUE: rbyte = hue_reg;
            picture_regs_pkg::IDX_CONTRAST: rbyte = contrast_reg;
            picture_regs_pkg::IDX_CODING: rbyte = coding_reg;
            picture_regs_pkg::IDX_NOTCH: rbyte = notch_reg;
            picture_regs_pkg::IDX_PINS: rbyte = pins_reg;
            picture_regs_pkg::IDX_CROP_HI: rbyte = crop_hi_reg;
            picture_regs_pkg::IDX_CROP_LO: rbyte = crop_lo_reg;
            picture_regs_pkg::IDX_MISC: rbyte = misc_reg;
            default: begin
                rbyte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= picture_regs_pkg::RESP_OKAY;
        end else if (clk_en_in) begin
            s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= {24'h000000, rd_hit ? rbyte : 8'h00};
                s_axi_rresp_out <= rd_hit ? picture_regs_pkg::RESP_OKAY : picture_regs_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Blanking window comes from another domain: three stages, change when last two agree
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            vblank_sync_reg <= 3'b000;
            vblank_reg <= 1'b0;
        end else if (clk_en_in) begin
            vblank_sync_reg <= {vblank_sync_reg[1:0], vblank_window_in};
            if (vblank_sync_reg[2] == vblank_sync_reg[1]) begin
                vblank_reg <= vblank_sync_reg[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_out <= '0;
        end else if (clk_en_in) begin
            if (luma_a_reg[picture_regs_pkg::LA_DOUBLE]) begin
                cfg_out.luma_mode <= picture_regs_pkg::LUMA_DOUBLE;
            end else if (luma_a_reg[picture_regs_pkg::LA_VBLANK_BYPASS] && vblank_reg) begin
                cfg_out.luma_mode <= picture_regs_pkg::LUMA_DOUBLE;
            end else begin
                cfg_out.luma_mode <= picture_regs_pkg::LUMA_YCBCR;
            end
            cfg_out.pedestal_present <= !luma_a_reg[picture_regs_pkg::LA_NO_PEDESTAL];
            cfg_out.raw_header_real <= !luma_a_reg[picture_regs_pkg::LA_RAW_HDR_OFF];
            cfg_out.header_byte <= luma_a_reg[picture_regs_pkg::LA_RAW_HDR_OFF] ? picture_regs_pkg::DUMMY_HDR : 8'h00;
            // signed delay
            // Negative codes run from 1000 (-1) to 1111 (-8), not plain two's complement
            cfg_out.luma_delay <= luma_a_reg[3] ? $signed({1'b1, ~luma_a_reg[2:0]}) : $signed(luma_a_reg[3:0]);
            cfg_out.trap_filter <= luma_b_reg[picture_regs_pkg::LB_TRAP];
            cfg_out.peak_gain <= picture_regs_pkg::peak_gain_t'(luma_b_reg[3:2]);
            case (luma_b_reg[1:0])
                2'b10: cfg_out.agc_mode <= picture_regs_pkg::AGC_FORCE_OFF;
                2'b11: cfg_out.agc_mode <= picture_regs_pkg::AGC_FORCE_ON;
                default: cfg_out.agc_mode <= picture_regs_pkg::AGC_AUTO;
            endcase
            cfg_out.brightness <= bright_reg;
            cfg_out.saturation <= sat_reg;
            cfg_out.contrast <= contrast_reg;
            cfg_out.hue <= secam_in ? 8'sh00 : $signed(hue_reg);
            if (coding_reg[picture_regs_pkg::CD_RANGE]) begin
                cfg_out.y_min <= 8'h01;
                cfg_out.y_max <= 8'hfe;
                cfg_out.c_min <= 8'h01;
                cfg_out.c_max <= 8'hfe;
            end else begin
                cfg_out.y_min <= 8'h10;
                cfg_out.y_max <= 8'heb;
                cfg_out.c_min <= 8'h10;
                cfg_out.c_max <= 8'hf0;
            end
            cfg_out.chroma_twos <= coding_reg[picture_regs_pkg::CD_FORMAT];
            cfg_out.bypass_sel <= (coding_reg[4:3] == 2'b11) ? 2'b00 : coding_reg[4:3];
            // reserved formats fall back to embedded syncs
            cfg_out.out_format <= (coding_reg[2:0] == 3'b000) ? 3'b000 : 3'b111;
            cfg_out.notch_sel <= notch_reg[1:0];
            cfg_out.crop_start <= crop_start_reg;
        end
    end

    // Wide-notch bit lives in another register bank; the filter reads it directly

    ////////////////////////////////////////////////////////////////////////
    // Pin muxes; clocks pass through a flop, so the clock pin is a sampled copy
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pins_out <= '0;
        end else if (clk_en_in) begin
            if (pins_reg[picture_regs_pkg::PIN_FID_SEL]) begin
                pins_out.field_identity_out <= pins_in.genlock;
            end else begin
                pins_out.field_identity_out <= pins_reg[picture_regs_pkg::PIN_A_LOCK] ? pins_in.hv_lock
                                                                                       : pins_in.field_id;
            end
            if (!pins_reg[picture_regs_pkg::PIN_VS_SEL]) begin
                pins_out.vsync_pal_out <= pins_in.vsync;
            end else begin
                pins_out.vsync_pal_out <= pins_reg[picture_regs_pkg::PIN_B_LOCK] ? pins_in.hv_lock
                                                                                  : pins_in.pal_line;
            end
            if (!pins_reg[picture_regs_pkg::PIN_GP_SEL]) begin
                pins_out.interrupt_request_out <= pins_in.irq;
            end else begin
                pins_out.interrupt_request_out <= misc_reg[picture_regs_pkg::MISC_GP_VERTICAL_BLANK_OUT] ? pins_in.vblank
                                                                                            : pins_in.gp_line;
            end
            pins_out.clock_out <= pins_reg[picture_regs_pkg::PIN_CLK_SEL] ? pins_in.pix_clk : pins_in.sys_clk;
        end
    end

    logic unused_wide;
    assign unused_wide = wide_notch_bit_in;

endmodule : picture_regs

// file: verification/picture_regs_properties.sv
module picture_regs_properties (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic secam_in,
    input wire picture_regs_pkg::picture_cfg_t cfg_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_wr_taken;
        clk_en_in && s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_rd_taken;
        clk_en_in && s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    property p_wr_resp;
        s_wr_taken |-> ##[1:3] s_axi_bvalid_out;
    endproperty
    property p_b_hold;
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    property p_rd_resp;
        s_rd_taken |=> s_axi_rvalid_out;
    endproperty
    property p_r_hold;
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out) && !s_axi_arready_out;
    endproperty
    property p_rdata_hi;
        s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000;
    endproperty
    property p_header;
        $past(resetn_in) |-> cfg_out.header_byte == (cfg_out.raw_header_real ? 8'h00 : 8'h40);
    endproperty
    property p_code_range;
        $past(resetn_in) |-> (cfg_out.y_min == 8'h10) ? (cfg_out.y_max == 8'heb && cfg_out.c_min == 8'h10
            && cfg_out.c_max == 8'hf0) : ({cfg_out.y_min, cfg_out.y_max, cfg_out.c_min, cfg_out.c_max} == 32'h01fe01fe);
    endproperty
    property p_hue_secam;
        (clk_en_in && secam_in) [*3] |-> cfg_out.hue == 8'h00;
    endproperty
    // Crop start moves only on a completed write
    property p_crop;
        $changed(cfg_out.crop_start) |-> $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2);
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
    a_r_hold: assert property (p_r_hold) else $error("read response dropped");
    a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
    a_header: assert property (p_header) else $error("header byte wrong");
    a_code_range: assert property (p_code_range) else $error("code range wrong");
    a_hue_secam: assert property (p_hue_secam) else $error("hue under secam");
    a_crop: assert property (p_crop) else $error("crop start moved");
endmodule : picture_regs_properties
bind picture_regs picture_regs_properties i_props (.*);

// file: verification/picture_regs_tb.sv
module picture_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic secam = 1'b0, vbw = 1'b0, en = 1'b1, awr, wrdy, bv, arr, rv;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdw;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, resp;
    picture_regs_pkg::pin_sources_t src = '0;
    picture_regs_pkg::picture_cfg_t cfg;
    picture_regs_pkg::pin_outputs_t pout;
    int mismatches = 0;
    int tests_run = 0;
    always #2 clk = ~clk;
    picture_regs i_dut (.core_clk_in(clk), .resetn_in(rst_n), .clk_en_in(en), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
        .secam_in(secam), .vblank_window_in(vbw), .wide_notch_bit_in(1'b0), .pins_in(src), .cfg_out(cfg),
        .pins_out(pout));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // Address and data offered together, each dropped once taken
    // No cycle limit in the bus tasks: the watchdog ends a hung wait
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [3:0] s = 4'h1);
        @(posedge clk);
        awaddr <= {i[5:0], 2'b00};
        wdata <= {24'h0, d};
        wstrb <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        resp = bresp;
        bready <= 1'b0;
        step(3);
    endtask : wr
    task automatic rdr(input logic [7:0] i);
        @(posedge clk);
        araddr <= {i[5:0], 2'b00};
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rdw = rdata;
        resp = rresp;
        rready <= 1'b0;
        #1;
    endtask : rdr
    task automatic rchk(input logic [7:0] i, input logic [7:0] e);
        rdr(i);
        cmp(rdw, {24'h0, e});
        cmp(resp, 2'b00);
    endtask : rchk
    function automatic logic [3:0] pexp(input logic [7:0] r, input picture_regs_pkg::pin_sources_t s);
        pexp[3] = r[3] ? s.genlock : (r[6] ? s.hv_lock : s.field_id);
        pexp[2] = r[2] ? (r[4] ? s.hv_lock : s.pal_line) : s.vsync;
        pexp[1] = r[1] ? (r[7] ? s.vblank : s.gp_line) : s.irq;
        pexp[0] = r[0] ? s.pix_clk : s.sys_clk;
    endfunction : pexp
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] ix [12] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h11, 8'h12, 8'h13};
        logic [7:0] rv0 [12] = '{8'h60, 8'h00, 8'h80, 8'h80, 8'h00, 8'h80, 8'h47, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
        foreach (ix[k]) rchk(ix[k], rv0[k]);
        cmp({cfg.luma_mode, cfg.pedestal_present, cfg.raw_header_real, cfg.header_byte, cfg.luma_delay}, 16'h0400);
        cmp({cfg.brightness, cfg.saturation, cfg.hue, cfg.contrast}, 32'h80800080);
        cmp({cfg.chroma_twos, cfg.bypass_sel, cfg.out_format, cfg.trap_filter, cfg.crop_start}, 17'h03800);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_luma();
        wr(8'h07, 8'h97);
        // Blanking still low, so double rate can only come from the override bit
        cmp({cfg.luma_mode, cfg.pedestal_present, cfg.raw_header_real, cfg.header_byte, cfg.luma_delay}, 16'h7007);
        @(posedge clk) vbw <= 1'b1;
        step(6);
        wr(8'h07, 8'h1b);
        cmp(cfg.luma_mode, 2'd1);
        cmp({cfg.luma_delay}, 4'hc);
        @(posedge clk) vbw <= 1'b0;
        step(6);
        cmp(cfg.luma_mode, 2'd0);
        for (int k = 0; k < 4; k++) begin
            wr(8'h08, 8'h40 | 8'(k * 5));
            cmp({cfg.trap_filter, cfg.peak_gain, cfg.agc_mode}, {1'b1, 2'(k), (k < 2) ? 2'd0 : 2'(k - 1)});
        end
        wr(8'h08, 8'hbf);
        rchk(8'h08, 8'h0f);
        cmp(cfg.trap_filter, 1'b0);
        $display("t_luma done");
    endtask : t_luma
    task automatic t_picture();
        logic [7:0] cd [5] = '{8'h20, 8'h0f, 8'h17, 8'h1f, 8'h61};
        wr(8'h09, 8'hff);
        wr(8'h0a, 8'h00);
        wr(8'h0b, 8'h80);
        wr(8'h0c, 8'hff);
        cmp({cfg.brightness, cfg.saturation, cfg.hue, cfg.contrast}, 32'hff0080ff);
        // Enable low: the secam change must not reach the outputs yet
        @(posedge clk) {en, secam} <= 2'b01;
        step(5);
        cmp({cfg.hue}, 8'h80);
        @(posedge clk) en <= 1'b1;
        step(5);
        cmp({cfg.hue}, 8'h00);
        @(posedge clk) secam <= 1'b0;
        foreach (cd[k]) begin
            wr(8'h0d, cd[k]);
            cmp({cfg.y_min, cfg.y_max, cfg.c_min, cfg.c_max}, cd[k][6] ? 32'h01fe01fe : 32'h10eb10f0);
            cmp({cfg.chroma_twos, cfg.bypass_sel, cfg.out_format}, {cd[k][5], (cd[k][4:3] == 2'b11) ? 2'b00 : cd[k][4:3],
                (cd[k][2:0] == 3'h0) ? 3'h0 : 3'h7});
        end
        rchk(8'h0d, 8'h61);
        wr(8'h0e, 8'hfe);
        cmp(cfg.notch_sel, 2'b10);
        rchk(8'h0e, 8'h02);
        $display("t_picture done");
    endtask : t_picture
    task automatic t_pins();
        logic [7:0] pr [5] = '{8'h00, 8'h0f, 8'h8f, 8'h54, 8'h44};
        foreach (pr[k]) begin
            wr(8'h0f, pr[k]);
            wr(8'h13, pr[k] & 8'h80);
            for (int j = 0; j < 2; j++) begin
                @(posedge clk) src <= j ? ~10'h24a : 10'h24a;
                step(3);
                cmp({pout}, {pexp(pr[k], src)});
            end
        end
        wr(8'h0f, 8'hff);
        rchk(8'h0f, 8'h5f);
        $display("t_pins done");
    endtask : t_pins
    task automatic t_crop();
        wr(8'h11, 8'h80);
        cmp({cfg.crop_start}, 10'h000);
        wr(8'h12, 8'hff);
        cmp({cfg.crop_start}, 10'h203);
        rchk(8'h12, 8'h03);
        wr(8'h11, 8'h7f);
        wr(8'h12, 8'h03, 4'h0);
        cmp({resp, cfg.crop_start}, {2'b00, 10'h203});
        wr(8'h12, 8'h03);
        cmp({cfg.crop_start}, 10'h1ff);
        rdr(8'h10);
        cmp(rdw, 32'h0);
        cmp(resp, 2'b10);
        $display("t_crop done");
    endtask : t_crop
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        step(2);
        t_reset();
        t_luma();
        t_picture();
        t_pins();
        t_crop();
        results();
    end
    // Whole run needs a few hundred cycles
    initial begin
        #80000;
        mismatches++;
        results();
    end
endmodule : picture_regs_tb
